// ### src/radio_mode_and_cal_control.sv
// mode decode, front-end drive, receive calibration sequencer and synthesizer words
// Contract
// - chip enable low: sleep, PA/power-down high
// - power state 0 standby, 01 idle
// - standby/idle: retain words, outputs parked
// - state 11 active, tx/rx pin chooses; code also needs PA enable high to transmit and low to receive
// - active PA-disabled: power-down low, band follows
// - receive band A: band select high
// - transmit: chosen band PA select low
// - calibration holds power-down high until done
// - calibration starts on enable rise, receive
// - status low while calibration runs
// - calibration completes within 68 ticks
// - result kept while enable high, awake
// - enable low clears, disables calibration
// - divide ratio from coarse, step, fraction
// - power-up loads documented synthesizer defaults
// - IF synthesizer defaults to integer mode
// - band bit 1 is A, 0 is B
// - IF words effective only when fractional
`timescale 1ns/1ns
module radio_mode_and_cal_control
  import radio_mode_pkg::*;
#(
  parameter int CAL_RUN_CYCLES = CAL_RUN_CYCLES_DEF
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // pins
  input wire logic i_chip_enable_pin,
  input wire logic i_tx_rx_select_pin,
  input wire logic i_pa_enable_pin,
  input wire logic i_cal_enable_pin,
  // configuration bits
  input wire logic i_power_state_hi,
  input wire logic i_power_state_lo,
  input wire logic i_band_bit,
  input wire logic i_synth_lock,
  // synthesizer write port
  input wire logic i_synth_load,
  input wire radio_mode_pkg::synth_words_t i_synth_words,
  // front-end drive
  output radio_mode_pkg::fe_drive_t o_fe_drive,
  // internal enables and state
  output radio_mode_pkg::func_en_t o_func_en,
  output radio_mode_pkg::power_mode_t o_mode,
  output logic o_status,
  output logic o_cal_active,
  output logic o_cal_valid,
  // synthesizer control
  output radio_mode_pkg::synth_words_t o_synth_words,
  output logic [8:0] o_rf_int_ratio,
  output logic [6:0] o_if_frac_num_eff,
  output logic [6:0] o_if_modulus_eff,
  output logic [4:0] o_if_coarse_eff,
  output logic [2:0] o_if_step_eff
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic ce_s;
  logic txrx_s;
  logic pa_s;
  logic cal_s;
  logic cal_prev_r;
  logic cal_rise;

  pin_sync3 u_sync_ce (.i_mclk(i_mclk), .i_rst(i_rst), .i_pin(i_chip_enable_pin), .o_level(ce_s));
  pin_sync3 u_sync_tr (.i_mclk(i_mclk), .i_rst(i_rst), .i_pin(i_tx_rx_select_pin), .o_level(txrx_s));
  pin_sync3 u_sync_pa (.i_mclk(i_mclk), .i_rst(i_rst), .i_pin(i_pa_enable_pin), .o_level(pa_s));
  pin_sync3 u_sync_cal (.i_mclk(i_mclk), .i_rst(i_rst), .i_pin(i_cal_enable_pin), .o_level(cal_s));

  // edge detect on the qualified level, in the same cycle it first reads high
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cal_prev_r <= 1'b0;
    end else begin
      cal_prev_r <= cal_s;
    end
  end
  assign cal_rise = cal_s & ~cal_prev_r;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  power_mode_t mode_nxt;
  logic rx_active;
  logic tx_active;

  function automatic power_mode_t decode_mode(input logic ce, input logic hi, input logic lo);
    if (!ce) begin
      decode_mode = MODE_SLEEP;
    end else if ({hi, lo} == PS_ACTIVE) begin
      decode_mode = MODE_ACTIVE;
    end else if ({hi, lo} == PS_IDLE) begin
      decode_mode = MODE_IDLE;
    end else if (!lo) begin
      decode_mode = MODE_STANDBY;
    end else begin
      decode_mode = MODE_STANDBY;
    end
  endfunction : decode_mode

  assign mode_nxt = decode_mode(ce_s, i_power_state_hi, i_power_state_lo);

  // mode register so every output but o_cal_active and o_cal_valid, which are decoded from cal_r, comes from a flop
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= MODE_SLEEP;
    end else begin
      o_mode <= mode_nxt;
    end
  end

  assign rx_active = (o_mode == MODE_ACTIVE) && !txrx_s && !pa_s;
  assign tx_active = (o_mode == MODE_ACTIVE) && txrx_s && pa_s;

  // ------------------------------------------------------------
  // calibration sequencer
  // ------------------------------------------------------------
  typedef enum {
    CAL_OFF,
    CAL_RUN,
    CAL_HOLD
  } cal_state_t;

  cal_state_t cal_r;
  cal_state_t cal_nxt;
  logic [$clog2(CAL_RUN_CYCLES+1)-1:0] cal_cnt_r;
  logic cal_done;

  assign cal_done = (cal_cnt_r == ($clog2(CAL_RUN_CYCLES+1))'(CAL_RUN_CYCLES - 1));

  // sleep or enable low always drops back to off, discarding the result
  always_comb begin
    cal_nxt = cal_r;
    case (cal_r)
      CAL_OFF: begin
        if (cal_rise && rx_active) begin
          cal_nxt = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (cal_done) begin
          cal_nxt = CAL_HOLD;
        end
      end
      CAL_HOLD: begin
        cal_nxt = CAL_HOLD;
      end
      default: begin
        cal_nxt = CAL_OFF;
      end
    endcase
    if (!cal_s || o_mode == MODE_SLEEP) begin
      cal_nxt = CAL_OFF;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cal_r <= CAL_OFF;
    end else begin
      cal_r <= cal_nxt;
    end
  end

  // run counter; bounded by the worst-case tick budget
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cal_cnt_r <= '0;
    end else if (cal_r == CAL_RUN && cal_nxt == CAL_RUN) begin
      cal_cnt_r <= cal_cnt_r + 1'b1;
    end else begin
      cal_cnt_r <= '0;
    end
  end

  // status low during the run, else lock indication
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= 1'b0;
    end else begin
      o_status <= (cal_nxt == CAL_RUN) ? 1'b0 : i_synth_lock;
    end
  end

  assign o_cal_active = (cal_r == CAL_RUN);
  assign o_cal_valid = (cal_r == CAL_HOLD);

  // ------------------------------------------------------------
  // front-end drive and function enables
  // ------------------------------------------------------------
  fe_drive_t fe_nxt;
  func_en_t en_nxt;

  always_comb begin
    fe_nxt = '{pa_select_band_a: 1'b1, pa_select_band_b: 1'b1, front_end_power_down: 1'b1, band_select_out: 1'b0};
    en_nxt = '0;
    case (o_mode)
      MODE_SLEEP: begin
        en_nxt = '0;
      end
      MODE_STANDBY: begin
        en_nxt.osc_en = 1'b1;
        en_nxt.serial_en = 1'b1;
      end
      MODE_IDLE: begin
        en_nxt.osc_en = 1'b1;
        en_nxt.serial_en = 1'b1;
        en_nxt.synth_en = 1'b1;
      end
      MODE_ACTIVE: begin
        en_nxt.osc_en = 1'b1;
        en_nxt.serial_en = 1'b1;
        en_nxt.synth_en = 1'b1;
        fe_nxt.band_select_out = i_band_bit;
        fe_nxt.front_end_power_down = 1'b0;
        if (tx_active) begin
          en_nxt.tx_en = 1'b1;
          fe_nxt.pa_select_band_a = ~i_band_bit;
          fe_nxt.pa_select_band_b = i_band_bit;
        end else if (rx_active) begin
          en_nxt.rx_en = 1'b1;
        end else if (!pa_s) begin
          en_nxt.tx_en = 1'b1;
          en_nxt.rx_en = 1'b1;
        end
        // keeping the front end dark during the run isolates the offset measurement
        if (cal_r == CAL_RUN) begin
          fe_nxt.front_end_power_down = 1'b1;
          en_nxt.rx_en = 1'b1;
          en_nxt.tx_en = 1'b0;
        end
      end
      default: begin
        en_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_fe_drive <= '{pa_select_band_a: 1'b1, pa_select_band_b: 1'b1, front_end_power_down: 1'b1,
                      band_select_out: 1'b0};
      o_func_en <= '0;
    end else begin
      o_fe_drive <= fe_nxt;
      o_func_en <= en_nxt;
    end
  end

  // ------------------------------------------------------------
  // synthesizer words
  // ------------------------------------------------------------
  // defaults load at reset and every cycle in sleep, IF words other than the enable only at reset; held in standby and idle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_synth_words <= '0;
      o_synth_words.prescale <= PRESCALE_RST;
      o_synth_words.rf_coarse_word <= RF_COARSE_RST;
      o_synth_words.rf_step_word <= RF_STEP_RST;
      o_synth_words.rf_fraction_num <= RF_FRAC_RST;
      o_synth_words.rf_modulus <= RF_MOD_RST;
      o_synth_words.if_fractional_enable <= IF_FRAC_EN_RST;
    end else if (o_mode == MODE_SLEEP) begin
      o_synth_words.prescale <= PRESCALE_RST;
      o_synth_words.rf_coarse_word <= RF_COARSE_RST;
      o_synth_words.rf_step_word <= RF_STEP_RST;
      o_synth_words.rf_fraction_num <= RF_FRAC_RST;
      o_synth_words.rf_modulus <= RF_MOD_RST;
      o_synth_words.if_fractional_enable <= IF_FRAC_EN_RST;
    end else if (i_synth_load) begin
      o_synth_words <= i_synth_words;
    end
  end

  // integer part: 8*(coarse+3) - step; the fraction rides to the sigma-delta separately
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rf_int_ratio <= '0;
    end else begin
      o_rf_int_ratio <= 9'((o_synth_words.rf_coarse_word + 9'h003) << 3) - 9'(o_synth_words.rf_step_word);
    end
  end

  // IF words pass only in fractional mode; integer mode zeroes them
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_if_frac_num_eff <= '0;
      o_if_modulus_eff <= '0;
      o_if_coarse_eff <= '0;
      o_if_step_eff <= '0;
    end else if (o_synth_words.if_fractional_enable) begin
      o_if_frac_num_eff <= o_synth_words.if_fraction_num;
      o_if_modulus_eff <= o_synth_words.if_modulus;
      o_if_coarse_eff <= o_synth_words.if_coarse_word;
      o_if_step_eff <= o_synth_words.if_step_word;
    end else begin
      o_if_frac_num_eff <= '0;
      o_if_modulus_eff <= '0;
      o_if_coarse_eff <= '0;
      o_if_step_eff <= '0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence cal_start_s;
    cal_r == CAL_OFF && cal_rise && rx_active && cal_s && o_mode != MODE_SLEEP;
  endsequence

  AST_SLEEP_DRIVE: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_mode == MODE_SLEEP |=> o_fe_drive == 4'hE && o_func_en == '0)
    else $error("sleep drive wrong");

  AST_IDLE_SYNTH: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_mode == MODE_IDLE |=> o_func_en.synth_en && !o_func_en.tx_en && o_fe_drive.front_end_power_down)
    else $error("idle enables wrong");

  AST_CAL_START: assert property (@(posedge i_mclk) disable iff (i_rst)
    cal_start_s |=> cal_r == CAL_RUN)
    else $error("calibration did not start");

  AST_CAL_NOSTART: assert property (@(posedge i_mclk) disable iff (i_rst)
    cal_r == CAL_OFF && !cal_rise |=> cal_r == CAL_OFF)
    else $error("calibration started without edge");

  AST_STATUS_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)
    cal_r == CAL_RUN |-> !o_status)
    else $error("status high during calibration");

  // helper: cycles spent in the current run, so the 68-tick budget needs no long delay range
  logic [11:0] run_len_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      run_len_r <= '0;
    end else if (cal_r == CAL_RUN) begin
      run_len_r <= run_len_r + 12'h001;
    end else begin
      run_len_r <= '0;
    end
  end

  AST_CAL_BOUND: assert property (@(posedge i_mclk) disable iff (i_rst)
    cal_r == CAL_RUN |-> run_len_r < 12'(CAL_MAX_TICKS * CAL_TICK_CYCLES))
    else $error("calibration overran");

  AST_CAL_CLEAR: assert property (@(posedge i_mclk) disable iff (i_rst)
    !cal_s |=> !o_cal_valid && !o_cal_active)
    else $error("calibration not cleared");

  AST_PD_HELD: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_cal_active && o_mode == MODE_ACTIVE |=> o_fe_drive.front_end_power_down)
    else $error("front end powered during calibration");

  AST_TX_PA: assert property (@(posedge i_mclk) disable iff (i_rst)
    tx_active && cal_r != CAL_RUN |=> o_fe_drive.pa_select_band_a == !$past(i_band_bit))
    else $error("wrong PA select");

endmodule : radio_mode_and_cal_control

// ### src/radio_mode_pkg.sv
// package: mode encodings, synthesizer defaults, ranges and calibration timing
package radio_mode_pkg;

  // clock and calibration timing
  localparam int CLK_MHZ = 25;
  localparam int CAL_TICK_REF_PERIODS = 44;
  localparam int CAL_MAX_TICKS = 68;
  localparam int CAL_TICK_CYCLES = CAL_TICK_REF_PERIODS;
  localparam int CAL_RUN_CYCLES_DEF = 2992;
  localparam int CAL_RESET_US = 4;
  localparam int CAL_RESET_CYCLES = CAL_RESET_US * CLK_MHZ;

  // power state codes
  localparam logic [1:0] PS_ACTIVE = 2'h3;
  localparam logic [1:0] PS_IDLE = 2'h1;

  // synthesizer reset values
  localparam logic PRESCALE_RST = 1'h1;
  localparam logic [4:0] RF_COARSE_RST = 5'h0A;
  localparam logic [2:0] RF_STEP_RST = 3'h0;
  localparam logic [6:0] RF_FRAC_RST = 7'h30;
  localparam logic [6:0] RF_MOD_RST = 7'h4F;
  localparam logic IF_FRAC_EN_RST = 1'h0;

  // legal ranges
  localparam logic [4:0] RF_COARSE_MIN = 5'h07;
  localparam logic [6:0] RF_MOD_MIN = 7'h20;

  // top-level mode
  typedef enum {
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_IDLE,
    MODE_ACTIVE
  } power_mode_t;

  // front-end drive group
  typedef struct packed {
    logic pa_select_band_a;
    logic pa_select_band_b;
    logic front_end_power_down;
    logic band_select_out;
  } fe_drive_t;

  // internal function enables
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic synth_en;
    logic osc_en;
    logic serial_en;
  } func_en_t;

  // synthesizer word group
  typedef struct packed {
    logic prescale;
    logic [4:0] rf_coarse_word;
    logic [2:0] rf_step_word;
    logic [6:0] rf_fraction_num;
    logic [6:0] rf_modulus;
    logic if_fractional_enable;
    logic [4:0] if_coarse_word;
    logic [2:0] if_step_word;
    logic [6:0] if_fraction_num;
    logic [6:0] if_modulus;
  } synth_words_t;

endpackage : radio_mode_pkg

// ### src/pin_sync3.sv
// three-stage pin synchroniser with agreement qualifier
`timescale 1ns/1ns
module pin_sync3 (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // pin side
  input wire logic i_pin,
  // synchronised level
  output logic o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // the first stage feeds only the second to keep metastability contained
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // level moves only once stages two and three agree
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else if (s2_r == s3_r) begin
      o_level <= s3_r;
    end
  end

endmodule : pin_sync3

// ### tb/rf_front_end_model.sv
// behavioural model of the external front end behind its p-mosfet switches
`timescale 1ns/1ns
module rf_front_end_model
  import radio_mode_pkg::*;
(
  // drive from the transceiver
  input wire radio_mode_pkg::fe_drive_t i_fe_drive,
  // powered sections
  output logic o_pa_a_on,
  output logic o_pa_b_on,
  output logic o_lna_on,
  output logic o_band_a
);
  // p-mosfet gates conduct when pulled low, so a low select powers its amplifier
  assign o_pa_a_on = !i_fe_drive.pa_select_band_a;
  assign o_pa_b_on = !i_fe_drive.pa_select_band_b;
  // shared receive path is only powered while power-down is low
  assign o_lna_on = !i_fe_drive.front_end_power_down;
  assign o_band_a = i_fe_drive.band_select_out;
endmodule : rf_front_end_model

// ### tb/radio_mode_and_cal_control_tb_top.sv
// self-checking bench for mode decode, front-end drive and receive calibration
`timescale 1ns/1ns
module radio_mode_and_cal_control_tb_top;
  import radio_mode_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // short calibration run keeps the bench quick
  localparam int CAL_RUN = 20;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_chip_enable_pin = 1'b0;
  logic i_tx_rx_select_pin = 1'b0;
  logic i_pa_enable_pin = 1'b0;
  logic i_cal_enable_pin = 1'b0;
  logic i_power_state_hi = 1'b0;
  logic i_power_state_lo = 1'b0;
  logic i_band_bit = 1'b0;
  logic i_synth_lock = 1'b0;
  logic i_synth_load = 1'b0;
  synth_words_t i_synth_words = '0;
  fe_drive_t o_fe_drive;
  func_en_t o_func_en;
  power_mode_t o_mode;
  logic o_status;
  logic o_cal_active;
  logic o_cal_valid;
  synth_words_t o_synth_words;
  logic [8:0] o_rf_int_ratio;
  logic [6:0] o_if_frac_num_eff;
  logic [6:0] o_if_modulus_eff;
  logic [4:0] o_if_coarse_eff;
  logic [2:0] o_if_step_eff;
  logic pa_a_on;
  logic pa_b_on;
  logic lna_on;
  logic band_a;
  int fails = 0;
  int total_checks = 0;

  // ----------------------------------------
  // instances
  // ----------------------------------------
  radio_mode_and_cal_control #(.CAL_RUN_CYCLES(CAL_RUN)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_chip_enable_pin(i_chip_enable_pin), .i_tx_rx_select_pin(i_tx_rx_select_pin),
    .i_pa_enable_pin(i_pa_enable_pin), .i_cal_enable_pin(i_cal_enable_pin),
    .i_power_state_hi(i_power_state_hi), .i_power_state_lo(i_power_state_lo), .i_band_bit(i_band_bit),
    .i_synth_lock(i_synth_lock), .i_synth_load(i_synth_load), .i_synth_words(i_synth_words),
    .o_fe_drive(o_fe_drive), .o_func_en(o_func_en), .o_mode(o_mode), .o_status(o_status),
    .o_cal_active(o_cal_active), .o_cal_valid(o_cal_valid), .o_synth_words(o_synth_words),
    .o_rf_int_ratio(o_rf_int_ratio), .o_if_frac_num_eff(o_if_frac_num_eff),
    .o_if_modulus_eff(o_if_modulus_eff), .o_if_coarse_eff(o_if_coarse_eff), .o_if_step_eff(o_if_step_eff));
  rf_front_end_model fe_u (.i_fe_drive(o_fe_drive), .o_pa_a_on(pa_a_on), .o_pa_b_on(pa_b_on),
    .o_lna_on(lna_on), .o_band_a(band_a));

  // clock: 40 ns period
  always #20 i_mclk = ~i_mclk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // pins pass a synchroniser plus two registers, so eight cycles always settles them
  task automatic drive(input logic ce, input logic [1:0] ps, input logic tr, input logic pa, input logic bd);
    @(posedge i_mclk);
    i_chip_enable_pin <= ce;
    {i_power_state_hi, i_power_state_lo} <= ps;
    i_tx_rx_select_pin <= tr;
    i_pa_enable_pin <= pa;
    i_band_bit <= bd;
    repeat (8) @(negedge i_mclk);
  endtask : drive

  task automatic load(input synth_words_t w);
    @(posedge i_mclk);
    i_synth_load <= 1'b1;
    i_synth_words <= w;
    @(posedge i_mclk);
    i_synth_load <= 1'b0;
    repeat (3) @(negedge i_mclk);
  endtask : load

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // tests
  // ----------------------------------------
  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge i_mclk);
    fails++;
    final_report();
  end

  initial begin
    synth_words_t w;
    int cnt;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (3) @(negedge i_mclk);
    chk("prescale", 9'(o_synth_words.prescale), 9'h001);
    chk("coarse", 9'(o_synth_words.rf_coarse_word), 9'h00A);
    chk("step", 9'(o_synth_words.rf_step_word), 9'h000);
    chk("frac", 9'(o_synth_words.rf_fraction_num), 9'h030);
    chk("mod", 9'(o_synth_words.rf_modulus), 9'h04F);
    chk("if_frac_en", 9'(o_synth_words.if_fractional_enable), 9'h000);
    chk("ratio", o_rf_int_ratio, 9'h068);
    chk("fe", 9'(o_fe_drive), 9'h00E);
    chk("en", 9'(o_func_en), 9'h000);
    chk("mode", 9'(o_mode), 9'(MODE_SLEEP));
    $display("test reset_sleep done");
    drive(1'b1, 2'h0, 1'b1, 1'b1, 1'b1);
    chk("mode", 9'(o_mode), 9'(MODE_STANDBY));
    chk("en", 9'(o_func_en), 9'h003);
    chk("fe", 9'(o_fe_drive), 9'h00E);
    drive(1'b1, 2'h2, 1'b1, 1'b1, 1'b1);
    chk("mode", 9'(o_mode), 9'(MODE_STANDBY));
    w = '0;
    w.prescale = 1'b1;
    w.rf_coarse_word = 5'h14;
    w.rf_step_word = 3'h5;
    w.rf_fraction_num = 7'h0A;
    w.rf_modulus = 7'h40;
    w.if_coarse_word = 5'h10;
    w.if_step_word = 3'h2;
    w.if_fraction_num = 7'h20;
    w.if_modulus = 7'h4F;
    load(w);
    chk("ratio", o_rf_int_ratio, 9'h0B3);
    chk("if_coarse_eff", 9'(o_if_coarse_eff), 9'h000);
    drive(1'b1, 2'h1, 1'b1, 1'b1, 1'b1);
    chk("mode", 9'(o_mode), 9'(MODE_IDLE));
    chk("en", 9'(o_func_en), 9'h007);
    chk("fe", 9'(o_fe_drive), 9'h00E);
    chk("ratio", o_rf_int_ratio, 9'h0B3);
    // the 40 MHz reference set-up a controller must program
    w.if_fractional_enable = 1'b1;
    load(w);
    chk("if_coarse_eff", 9'(o_if_coarse_eff), 9'h010);
    chk("if_step_eff", 9'(o_if_step_eff), 9'h002);
    chk("if_frac_eff", 9'(o_if_frac_num_eff), 9'h020);
    chk("if_mod_eff", 9'(o_if_modulus_eff), 9'h04F);
    $display("test standby_idle done");
    @(posedge i_mclk);
    i_synth_lock <= 1'b1;
    drive(1'b1, 2'h3, 1'b1, 1'b0, 1'b0);
    chk("mode", 9'(o_mode), 9'(MODE_ACTIVE));
    chk("fe", 9'(o_fe_drive), 9'h00C);
    chk("en", 9'(o_func_en), 9'h01F);
    drive(1'b1, 2'h3, 1'b1, 1'b1, 1'b1);
    chk("fe", 9'(o_fe_drive), 9'h005);
    chk("en", 9'(o_func_en), 9'h017);
    chk("pa_a_on", 9'(pa_a_on), 9'h001);
    drive(1'b1, 2'h3, 1'b1, 1'b1, 1'b0);
    chk("fe", 9'(o_fe_drive), 9'h008);
    chk("pa_b_on", 9'(pa_b_on), 9'h001);
    drive(1'b1, 2'h3, 1'b0, 1'b0, 1'b1);
    chk("fe", 9'(o_fe_drive), 9'h00D);
    chk("en", 9'(o_func_en), 9'h00F);
    chk("lna_on", 9'(lna_on), 9'h001);
    $display("test active done");
    // controller waits for lock before asking for calibration
    chk("status", 9'(o_status), 9'h001);
    @(posedge i_mclk);
    i_cal_enable_pin <= 1'b1;
    cnt = 0;
    while (o_cal_active !== 1'b1 && cnt < 10) begin
      @(negedge i_mclk);
      cnt++;
    end
    chk("cal_active", 9'(o_cal_active), 9'h001);
    chk("status", 9'(o_status), 9'h000);
    cnt = 0;
    while (o_cal_active === 1'b1 && cnt < CAL_RUN + 20) begin
      @(negedge i_mclk);
      cnt++;
      if (cnt == 3) begin
        chk("fe_cal", 9'(o_fe_drive), 9'h00F);
      end
    end
    chk("cal_len", 9'(cnt >= CAL_RUN - 2 && cnt <= CAL_RUN + 1), 9'h001);
    chk("cal_valid", 9'(o_cal_valid), 9'h001);
    repeat (2) @(negedge i_mclk);
    chk("status", 9'(o_status), 9'h001);
    chk("fe", 9'(o_fe_drive), 9'h00D);
    repeat (20) @(negedge i_mclk);
    chk("cal_valid", 9'(o_cal_valid), 9'h001);
    @(posedge i_mclk);
    i_cal_enable_pin <= 1'b0;
    repeat (8) @(negedge i_mclk);
    chk("cal_valid", 9'(o_cal_valid), 9'h000);
    $display("test calibration done");
    // a rise outside receive must be ignored, and staying high must not relaunch
    drive(1'b1, 2'h3, 1'b1, 1'b1, 1'b1);
    @(posedge i_mclk);
    i_cal_enable_pin <= 1'b1;
    repeat (10) @(negedge i_mclk);
    chk("cal_active", 9'(o_cal_active), 9'h000);
    drive(1'b1, 2'h3, 1'b0, 1'b0, 1'b1);
    chk("cal_active", 9'(o_cal_active), 9'h000);
    @(posedge i_mclk);
    i_cal_enable_pin <= 1'b0;
    repeat (8) @(posedge i_mclk);
    i_cal_enable_pin <= 1'b1;
    repeat (8) @(negedge i_mclk);
    chk("cal_active", 9'(o_cal_active), 9'h001);
    drive(1'b0, 2'h3, 1'b0, 1'b0, 1'b1);
    chk("cal_active", 9'(o_cal_active), 9'h000);
    chk("cal_valid", 9'(o_cal_valid), 9'h000);
    chk("fe", 9'(o_fe_drive), 9'h00E);
    chk("coarse", 9'(o_synth_words.rf_coarse_word), 9'h00A);
    $display("test cal_refuse_sleep done");
    final_report();
  end
endmodule : radio_mode_and_cal_control_tb_top
